//--- exp_nco_pkg.sv
package exp_nco_pkg;

  localparam int MANT_W  = 14;
  localparam int EXP_W   = 3;
  localparam int SCALE_W = 5;
  localparam int REG_W   = 16;
  localparam int ADDR_W  = 8;
  localparam int OUT_W   = 16;
  localparam int ACC_W   = 32;
  localparam int LUT_AW  = 4;

  // Register offsets
  localparam logic [7:0] UPDATE_CONTROL_OFS  = 8'h83;
  localparam logic [7:0] HOLDOFF_COUNT_OFS   = 8'h84;
  localparam logic [7:0] TUNING_LOW_OFS      = 8'h85;
  localparam logic [7:0] TUNING_HIGH_OFS     = 8'h86;
  localparam logic [7:0] PHASE_OFFSET_OFS    = 8'h87;
  localparam logic [7:0] OSC_CONTROL_OFS     = 8'h88;
  localparam logic [7:0] TUNER_STATUS_OFS    = 8'h89;
  localparam logic [7:0] HOLDOFF_REMAIN_OFS  = 8'h8a;
  localparam logic [7:0] ACTIVE_LOW_OFS      = 8'h8b;
  localparam logic [7:0] ACTIVE_HIGH_OFS     = 8'h8c;
  localparam logic [7:0] EXPONENT_CTRL_OFS   = 8'h91;
  localparam logic [7:0] GAIN_SCALE_PAIR_OFS = 8'h92;

  // Field positions
  localparam int CTRL_BYPASS_BIT    = 0;
  localparam int CTRL_PH_DITHER_BIT = 1;
  localparam int CTRL_AM_DITHER_BIT = 2;
  localparam int CTRL_CLR_HOP_BIT   = 3;
  localparam int UPD_START_BIT      = 0;
  localparam int UPD_SYNC_BIT       = 1;
  localparam int EXPC_INVERT_BIT    = 0;
  localparam int EXPC_OFFSET_LSB    = 1;
  localparam int ATTEN_SCALE_LSB    = 0;
  localparam int UNATTEN_SCALE_LSB  = 5;

  // Values after reset
  localparam logic [15:0] HOLDOFF_RST   = 16'h0000;
  localparam logic [15:0] TUNING_RST    = 16'h0000;
  localparam logic [15:0] PHASE_OFS_RST = 16'h0000;
  localparam logic [3:0]  OSC_CTRL_RST  = 4'h0;
  localparam logic [9:0]  SCALE_RST     = 10'h000;
  localparam logic [3:0]  EXPC_RST      = 4'h0;
  localparam logic [15:0] LFSR_SEED     = 16'hace1;
  localparam logic [15:0] LFSR_TAPS     = 16'hb400;

  // Exponent inversion base: shift = 7 - exponent
  localparam logic [2:0] EXP_INV_BASE = 3'h7;

  // Quarter-wave sine, centred on half steps
  localparam logic [15:0] SINE_QTR [16] = '{
    16'h0648, 16'h12c8, 16'h1f1a, 16'h2b1f,
    16'h36ba, 16'h41ce, 16'h4c3f, 16'h55f5,
    16'h5ed7, 16'h66cf, 16'h6dc9, 16'h73b5,
    16'h7883, 16'h7c29, 16'h7e9c, 16'h7fd8};

  localparam logic [15:0] QUARTER_TURN = 16'h4000;

endpackage

//--- dither_lfsr.sv
`timescale 1ns/1ps
`default_nettype none
module dither_lfsr
  import exp_nco_pkg::*;
#(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  // Random word
  output logic     [W-1:0]  rnd_o
);

  typedef struct packed {
    logic [W-1:0] sr;
  } lfsr_state_t;

  lfsr_state_t st_r;
  lfsr_state_t st_nxt;

  // Galois form: free running so dither never repeats with the sample rate
  always_comb begin
    st_nxt = st_r;
    if (st_r.sr[0]) begin
      st_nxt.sr = (st_r.sr >> 1) ^ W'(LFSR_TAPS);
    end else begin
      st_nxt.sr = st_r.sr >> 1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      st_r.sr <= W'(LFSR_SEED);
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rnd_o = st_r.sr;

endmodule
`default_nettype wire

//--- sincos_lut.sv
`timescale 1ns/1ps
`default_nettype none
module sincos_lut
  import exp_nco_pkg::*;
(
  // Phase in
  input  wire logic        [15:0] phase_i,
  input  wire logic               am_dither_i,
  input  wire logic        [1:0]  dith_i,
  // Cartesian out
  output logic signed      [15:0] cos_o,
  output logic signed      [15:0] sin_o
);

  function automatic logic signed [15:0] sine_of(
    input logic [15:0] ph,
    input logic        dbit
  );
    logic [3:0]  idx;
    logic [15:0] mag;
    idx = ph[14] ? ~ph[13:10] : ph[13:10];
    mag = SINE_QTR[idx] + {15'h0000, dbit};
    sine_of = ph[15] ? -$signed(mag) : $signed(mag);
  endfunction

  // Amplitude dither nudges the table magnitude by one LSB
  always_comb begin
    sin_o = sine_of(phase_i, am_dither_i & dith_i[0]);
    cos_o = sine_of(phase_i + QUARTER_TURN, am_dither_i & dith_i[1]);
  end

endmodule
`default_nettype wire

//--- exp_nco_tuner.sv
// How it works
// - Inverted exponent: right shift is (7 - exp + scale) mod 8.
// - Non-inverted: shift right grows with exponent, exp 5 shifts five.
// - Inverted: shift shrinks as exponent rises.
// - Inverted, no offset: exp 5 shifts two, exp 0 shifts seven.
// - Exponent offset joins the mod-8 sum; offset 6 makes inverted exp 5 unshifted.
// - Exponent offset is freely programmable, any of eight values.
// - Two 5-bit scales; level indicator selects attenuated or unattenuated.
// - Complex oscillator, 32-bit accumulator, two multipliers.
// - 32-bit tuning word split over low and high registers.
// - Tuning writes go to shadow; moved by soft sync or hold-off update.
// - 16-bit hold-off counter counts master clocks.
// - 16-bit phase offset added to accumulator phase.
// - Control bit 0 bypasses the oscillator.
// - Bypass puts port A on in-phase and port B on quadrature.
// - Control bit 1 enables phase dither.
// - Control bit 2 enables amplitude dither, independent of phase dither.
// - Control bit 3 clears accumulator on each hop; offset still applies.
// - Bit 3 clear: hop continues from last phase.
// - Oscillator settings belong to this channel instance alone.
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module exp_nco_tuner
  import exp_nco_pkg::*;
(
  // Clock and reset
  input  wire logic                         REF_CLK_I,
  input  wire logic                         RSTN_I,
  // Register port
  input  wire logic [exp_nco_pkg::ADDR_W-1:0] REG_ADDR_I,
  input  wire logic [exp_nco_pkg::REG_W-1:0]  REG_WDATA_I,
  input  wire logic                         REG_WR_I,
  input  wire logic                         REG_RD_I,
  output logic      [exp_nco_pkg::REG_W-1:0]  REG_RDATA_O,
  // Converter port A
  input  wire logic [exp_nco_pkg::MANT_W-1:0] ADC_A_MANT_I,
  input  wire logic [exp_nco_pkg::EXP_W-1:0]  ADC_A_EXP_I,
  // Converter port B
  input  wire logic [exp_nco_pkg::MANT_W-1:0] ADC_B_MANT_I,
  input  wire logic [exp_nco_pkg::EXP_W-1:0]  ADC_B_EXP_I,
  // Sample control
  input  wire logic                         SAMPLE_VALID_I,
  input  wire logic                         LEVEL_INDICATOR_I,
  input  wire logic                         SOFT_SYNC_I,
  // Tuned output
  output logic      [exp_nco_pkg::OUT_W-1:0]  I_DATA_O,
  output logic      [exp_nco_pkg::OUT_W-1:0]  Q_DATA_O,
  output logic                              DATA_VALID_O,
  output logic                              HOLDOFF_BUSY_O
);

  import exp_nco_pkg::*;

  typedef struct packed {
    logic [REG_W-1:0]        holdoff_count;
    logic [REG_W-1:0]        tuning_word_low;
    logic [REG_W-1:0]        tuning_word_high;
    logic [REG_W-1:0]        phase_offset;
    logic [3:0]              oscillator_control;
    logic [9:0]              gain_scale_pair;
    logic [3:0]              exponent_control;
    logic [ACC_W-1:0]        active_word;
    logic [ACC_W-1:0]        acc;
    logic [REG_W-1:0]        hold_cnt;
    logic                    hold_busy;
    logic [REG_W-1:0]        rdata;
    logic signed [MANT_W-1:0] samp_a;
    logic signed [MANT_W-1:0] samp_b;
    logic [15:0]             phase;
    logic                    byp1;
    logic                    v1;
    logic [OUT_W-1:0]        i_out;
    logic [OUT_W-1:0]        q_out;
    logic                    v_out;
  } tuner_state_t;

  tuner_state_t st_r;
  tuner_state_t st_nxt;

  logic [15:0]            rnd;
  logic signed [15:0]     cos_w;
  logic signed [15:0]     sin_w;
  logic                   bypass;
  logic                   ph_dither;
  logic                   am_dither;
  logic                   clr_on_hop;
  logic                   exp_inv;
  logic [2:0]             exp_ofs;
  logic [SCALE_W-1:0]     scale_sel;

  // Shift amount for one port; inversion flips exponent weight
  function automatic logic [2:0] shift_of(
    input logic [EXP_W-1:0]   e,
    input logic               inv,
    input logic [2:0]         ofs,
    input logic [SCALE_W-1:0] sc
  );
    logic [2:0] base;
    base = inv ? (EXP_INV_BASE - e) : e;
    shift_of = base + sc[2:0] + ofs;
  endfunction

  // Arithmetic right shift keeps the sign of the mantissa
  function automatic logic signed [MANT_W-1:0] scale_of(
    input logic [MANT_W-1:0] m,
    input logic [2:0]        sh
  );
    scale_of = $signed(m) >>> sh;
  endfunction

  // Product of sample and oscillator, cut to output width
  function automatic logic [OUT_W-1:0] mix_of(
    input logic signed [MANT_W-1:0] s,
    input logic signed [15:0]       c
  );
    logic signed [MANT_W+15:0] p;
    p = s * c;
    mix_of = p[MANT_W+14:MANT_W-1];
  endfunction

  // Bypassed sample aligned to the product's scale
  function automatic logic [OUT_W-1:0] align_of(
    input logic signed [MANT_W-1:0] s
  );
    align_of = {s, 2'b00};
  endfunction

  dither_lfsr #(
    .W (16)
  ) u_dither (
    .clk_i  (REF_CLK_I),
    .rstn_i (RSTN_I),
    .rnd_o  (rnd)
  );

  sincos_lut u_lut (
    .phase_i     (st_r.phase),
    .am_dither_i (am_dither),
    .dith_i      (rnd[15:14]),
    .cos_o       (cos_w),
    .sin_o       (sin_w)
  );

  // Each instance keeps its own copy of every setting
  assign bypass     = st_r.oscillator_control[CTRL_BYPASS_BIT];
  assign ph_dither  = st_r.oscillator_control[CTRL_PH_DITHER_BIT];
  assign am_dither  = st_r.oscillator_control[CTRL_AM_DITHER_BIT];
  assign clr_on_hop = st_r.oscillator_control[CTRL_CLR_HOP_BIT];
  assign exp_inv    = st_r.exponent_control[EXPC_INVERT_BIT];
  assign exp_ofs    = st_r.exponent_control[EXPC_OFFSET_LSB +: 3];

  // Level indicator picks which of the two scales feeds the sum
  assign scale_sel = LEVEL_INDICATOR_I ?
                     st_r.gain_scale_pair[ATTEN_SCALE_LSB +: SCALE_W] :
                     st_r.gain_scale_pair[UNATTEN_SCALE_LSB +: SCALE_W];

  always_comb begin
    logic [ACC_W-1:0] acc_base;
    logic [ACC_W-1:0] acc_dith;
    logic             hop;
    logic             load_now;
    logic             start;
    acc_base = st_r.acc;
    acc_dith = 32'h0000_0000;
    hop      = 1'b0;
    load_now = 1'b0;
    start    = 1'b0;
    st_nxt   = st_r;

    // Register writes; tuning words land in the shadow pair
    if (REG_WR_I) begin
      unique case (REG_ADDR_I)
        HOLDOFF_COUNT_OFS: begin
          st_nxt.holdoff_count = REG_WDATA_I;
        end
        TUNING_LOW_OFS: begin
          st_nxt.tuning_word_low = REG_WDATA_I;
        end
        TUNING_HIGH_OFS: begin
          st_nxt.tuning_word_high = REG_WDATA_I;
        end
        PHASE_OFFSET_OFS: begin
          st_nxt.phase_offset = REG_WDATA_I;
        end
        OSC_CONTROL_OFS: begin
          st_nxt.oscillator_control = REG_WDATA_I[3:0];
        end
        EXPONENT_CTRL_OFS: begin
          st_nxt.exponent_control = REG_WDATA_I[3:0];
        end
        GAIN_SCALE_PAIR_OFS: begin
          st_nxt.gain_scale_pair = REG_WDATA_I[9:0];
        end
        UPDATE_CONTROL_OFS: begin
          if (REG_WDATA_I[UPD_START_BIT]) begin
            st_nxt.hold_cnt  = st_r.holdoff_count;
            st_nxt.hold_busy = 1'b1;
            start            = 1'b1;
          end
          load_now = REG_WDATA_I[UPD_SYNC_BIT];
        end
        default: begin
        end
      endcase
    end

    // Hold-off counts master clocks, hop on expiry
    // A restart wins over the running count, so no stale hop follows
    if (st_r.hold_busy && !start) begin
      if (st_r.hold_cnt == 16'h0000) begin
        st_nxt.hold_busy = 1'b0;
        hop = 1'b1;
      end else begin
        st_nxt.hold_cnt = st_r.hold_cnt - 16'h0001;
      end
    end

    // Soft sync loads the shadow word directly
    if (SOFT_SYNC_I || load_now) begin
      hop = 1'b1;
      st_nxt.hold_busy = 1'b0;
    end

    if (hop) begin
      st_nxt.active_word = {st_r.tuning_word_high,
                            st_r.tuning_word_low};
      if (clr_on_hop) begin
        acc_base = 32'h0000_0000;
      end else begin
        acc_base = st_r.acc;
      end
    end

    // Accumulator advances once per accepted sample
    if (SAMPLE_VALID_I) begin
      st_nxt.acc = acc_base + st_r.active_word;
    end else begin
      st_nxt.acc = acc_base;
    end

    // Phase dither fills the truncated bits with noise
    if (ph_dither) begin
      acc_dith = {16'h0000, rnd};
    end

    // Stage one: scale both ports and form the phase
    // Phase uses the pre-increment value, so a cleared hop starts at offset
    st_nxt.v1 = SAMPLE_VALID_I;
    if (SAMPLE_VALID_I) begin
      st_nxt.samp_a = scale_of(ADC_A_MANT_I,
        shift_of(ADC_A_EXP_I, exp_inv, exp_ofs, scale_sel));
      st_nxt.samp_b = scale_of(ADC_B_MANT_I,
        shift_of(ADC_B_EXP_I, exp_inv, exp_ofs, scale_sel));
      st_nxt.phase = 16'((acc_base + acc_dith) >> 16)
                   + st_r.phase_offset;
      st_nxt.byp1 = bypass;
    end

    // Stage two: mix, or pass A as I and B as Q
    // Only port A is mixed; port B reaches the output in bypass alone
    st_nxt.v_out = st_r.v1;
    if (st_r.v1) begin
      if (st_r.byp1) begin
        st_nxt.i_out = align_of(st_r.samp_a);
        st_nxt.q_out = align_of(st_r.samp_b);
      end else begin
        st_nxt.i_out = mix_of(st_r.samp_a, cos_w);
        st_nxt.q_out = mix_of(st_r.samp_a, sin_w);
      end
    end

    // Read data stands only in the cycle after the strobe
    st_nxt.rdata = 16'h0000;
    if (REG_RD_I) begin
      unique case (REG_ADDR_I)
        HOLDOFF_COUNT_OFS: begin
          st_nxt.rdata = st_r.holdoff_count;
        end
        TUNING_LOW_OFS: begin
          st_nxt.rdata = st_r.tuning_word_low;
        end
        TUNING_HIGH_OFS: begin
          st_nxt.rdata = st_r.tuning_word_high;
        end
        PHASE_OFFSET_OFS: begin
          st_nxt.rdata = st_r.phase_offset;
        end
        OSC_CONTROL_OFS: begin
          st_nxt.rdata = {12'h000, st_r.oscillator_control};
        end
        TUNER_STATUS_OFS: begin
          st_nxt.rdata = {15'h0000, st_r.hold_busy};
        end
        HOLDOFF_REMAIN_OFS: begin
          st_nxt.rdata = st_r.hold_cnt;
        end
        ACTIVE_LOW_OFS: begin
          st_nxt.rdata = st_r.active_word[15:0];
        end
        ACTIVE_HIGH_OFS: begin
          st_nxt.rdata = st_r.active_word[31:16];
        end
        EXPONENT_CTRL_OFS: begin
          st_nxt.rdata = {12'h000, st_r.exponent_control};
        end
        GAIN_SCALE_PAIR_OFS: begin
          st_nxt.rdata = {6'h00, st_r.gain_scale_pair};
        end
        // Unmapped and write-only addresses read as zero
        default: begin
          st_nxt.rdata = 16'h0000;
        end
      endcase
    end
  end

  // Datapath state clears too, so outputs start at zero after reset
  always_ff @(posedge REF_CLK_I) begin
    if (!RSTN_I) begin
      st_r                    <= '0;
      st_r.holdoff_count      <= HOLDOFF_RST;
      st_r.tuning_word_low    <= TUNING_RST;
      st_r.tuning_word_high   <= TUNING_RST;
      st_r.phase_offset       <= PHASE_OFS_RST;
      st_r.oscillator_control <= OSC_CTRL_RST;
      st_r.gain_scale_pair    <= SCALE_RST;
      st_r.exponent_control   <= EXPC_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign REG_RDATA_O    = st_r.rdata;
  assign I_DATA_O       = st_r.i_out;
  assign Q_DATA_O       = st_r.q_out;
  assign DATA_VALID_O   = st_r.v_out;
  assign HOLDOFF_BUSY_O = st_r.hold_busy;

endmodule
`default_nettype wire

//--- exp_nco_tuner_chk.sv
`timescale 1ns/1ps
`default_nettype none
module exp_nco_tuner_chk
  import exp_nco_pkg::*;
(
  // Clock and reset
  input wire logic                             REF_CLK_I,
  input wire logic                             RSTN_I,
  // Register port
  input wire logic [exp_nco_pkg::ADDR_W-1:0] REG_ADDR_I,
  input wire logic [exp_nco_pkg::REG_W-1:0]  REG_WDATA_I,
  input wire logic                             REG_WR_I,
  input wire logic                             REG_RD_I,
  input wire logic [exp_nco_pkg::REG_W-1:0]  REG_RDATA_O,
  // Samples and results
  input wire logic [exp_nco_pkg::MANT_W-1:0] ADC_A_MANT_I,
  input wire logic [exp_nco_pkg::MANT_W-1:0] ADC_B_MANT_I,
  input wire logic [exp_nco_pkg::EXP_W-1:0]  ADC_A_EXP_I,
  input wire logic [exp_nco_pkg::EXP_W-1:0]  ADC_B_EXP_I,
  input wire logic                             LEVEL_INDICATOR_I,
  input wire logic                             SAMPLE_VALID_I,
  input wire logic                             SOFT_SYNC_I,
  input wire logic [exp_nco_pkg::OUT_W-1:0]  I_DATA_O,
  input wire logic [exp_nco_pkg::OUT_W-1:0]  Q_DATA_O,
  input wire logic                             DATA_VALID_O,
  input wire logic                             HOLDOFF_BUSY_O
);
  logic [3:0]  ctrl_r;
  logic [3:0]  expc_r;
  logic [9:0]  gsp_r;
  logic [4:0]  sc_w;
  logic [15:0] byp_a;
  logic [15:0] byp_b;
  logic        upd;
  // Expected bypass word: mantissa after the mod-8 shift, two zero LSBs
  function automatic logic [15:0] byp_ref(input logic [13:0] m,
    input logic [2:0] e, input logic [3:0] xc, input logic [4:0] sc);
    logic [2:0] sh;
    sh = (xc[0] ? 3'h7 - e : e) + sc[2:0] + xc[3:1];
    byp_ref = {14'($signed(m) >>> sh), 2'b00};
  endfunction
  assign upd   = REG_WR_I && REG_ADDR_I == UPDATE_CONTROL_OFS;
  assign sc_w  = LEVEL_INDICATOR_I ? gsp_r[4:0] : gsp_r[9:5];
  assign byp_a = byp_ref(ADC_A_MANT_I, ADC_A_EXP_I, expc_r, sc_w);
  assign byp_b = byp_ref(ADC_B_MANT_I, ADC_B_EXP_I, expc_r, sc_w);
  // Mirrors of the settings, so bypass data can be predicted
  always_ff @(posedge REF_CLK_I) begin
    if (!RSTN_I) begin
      ctrl_r <= 4'h0;
      expc_r <= 4'h0;
      gsp_r  <= 10'h000;
    end else if (REG_WR_I) begin
      if (REG_ADDR_I == OSC_CONTROL_OFS)
        ctrl_r <= REG_WDATA_I[3:0];
      if (REG_ADDR_I == EXPONENT_CTRL_OFS)
        expc_r <= REG_WDATA_I[3:0];
      if (REG_ADDR_I == GAIN_SCALE_PAIR_OFS)
        gsp_r <= REG_WDATA_I[9:0];
    end
  end
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RSTN_I);
  AST_VALID_LAT: assert property (SAMPLE_VALID_I |-> ##2 DATA_VALID_O)
    else $error("no output two cycles after a sample");
  AST_VALID_CAUSE: assert property (DATA_VALID_O |-> $past(SAMPLE_VALID_I, 2))
    else $error("output valid without a sample");
  AST_HOLD: assert property (!DATA_VALID_O |-> $stable(I_DATA_O) && $stable(Q_DATA_O))
    else $error("outputs moved without valid");
  AST_RD_IDLE: assert property (!$past(REG_RD_I) |-> REG_RDATA_O == '0)
    else $error("read data outside read slot");
  AST_CTRL_RD: assert property (REG_RD_I && REG_ADDR_I == OSC_CONTROL_OFS |=>
    REG_RDATA_O == {12'h000, $past(ctrl_r)})
    else $error("control readback wrong");
  AST_BYPASS: assert property (ctrl_r[0] && SAMPLE_VALID_I |-> ##2
    I_DATA_O == $past(byp_a, 2) && Q_DATA_O == $past(byp_b, 2))
    else $error("bypass data wrong");
  AST_START: assert property (upd && REG_WDATA_I[0] && !REG_WDATA_I[1] && !SOFT_SYNC_I |=> HOLDOFF_BUSY_O)
    else $error("hold-off did not start");
  AST_SYNC: assert property (SOFT_SYNC_I || (upd && REG_WDATA_I[1]) |=> !HOLDOFF_BUSY_O)
    else $error("immediate load left hold-off busy");
  AST_STATUS: assert property (REG_RD_I && REG_ADDR_I == TUNER_STATUS_OFS |=>
    REG_RDATA_O[0] == $past(HOLDOFF_BUSY_O))
    else $error("status bit differs from busy");
  CV_BYP: cover property (ctrl_r[0] && SAMPLE_VALID_I);
  CV_BUSY: cover property ($fell(HOLDOFF_BUSY_O));
  CV_SYNC: cover property (SOFT_SYNC_I);
endmodule
bind exp_nco_tuner exp_nco_tuner_chk chk (.REF_CLK_I(REF_CLK_I),
  .RSTN_I(RSTN_I), .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I),
  .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O),
  .ADC_A_MANT_I(ADC_A_MANT_I), .ADC_B_MANT_I(ADC_B_MANT_I),
  .ADC_A_EXP_I(ADC_A_EXP_I), .ADC_B_EXP_I(ADC_B_EXP_I),
  .LEVEL_INDICATOR_I(LEVEL_INDICATOR_I),
  .SAMPLE_VALID_I(SAMPLE_VALID_I), .SOFT_SYNC_I(SOFT_SYNC_I),
  .I_DATA_O(I_DATA_O), .Q_DATA_O(Q_DATA_O), .DATA_VALID_O(DATA_VALID_O),
  .HOLDOFF_BUSY_O(HOLDOFF_BUSY_O));
`default_nettype wire

//--- adc_model.sv
`timescale 1ns/1ps
`default_nettype none
module adc_model
  import exp_nco_pkg::*;
#(
  parameter int BITS = 11
) (
  // Clock
  input  wire logic              clk_i,
  // Codes chosen by the bench
  input  wire logic [BITS-1:0]   code_a_i,
  input  wire logic [BITS-1:0]   code_b_i,
  input  wire logic [EXP_W-1:0]  gain_i,
  // Converter pins
  output logic      [MANT_W-1:0] mant_a_o,
  output logic      [MANT_W-1:0] mant_b_o,
  output logic      [EXP_W-1:0]  exp_a_o,
  output logic      [EXP_W-1:0]  exp_b_o
);
  // One pipeline stage, so codes change just after an edge
  always_ff @(posedge clk_i) begin
    mant_a_o <= {code_a_i, {(MANT_W-BITS){1'b0}}};
    mant_b_o <= {code_b_i, {(MANT_W-BITS){1'b0}}};
    exp_a_o  <= gain_i;
    exp_b_o  <= gain_i;
  end
endmodule
`default_nettype wire

//--- exp_nco_tuner_bench.sv
`timescale 1ns/1ps
`default_nettype none
module exp_nco_tuner_bench;
  import exp_nco_pkg::*;
  logic        clk    = 1'b0;
  logic        rstn   = 1'b0;
  logic [7:0]  addr   = 8'h00;
  logic [15:0] wdata  = 16'h0000;
  logic        wr     = 1'b0;
  logic        rd     = 1'b0;
  logic        sv     = 1'b0;
  logic        li     = 1'b0;
  logic        ss     = 1'b0;
  logic [10:0] code_a = 11'h000;
  logic [10:0] code_b = 11'h000;
  logic [2:0]  gain   = 3'h0;
  logic [13:0] mant_a, mant_b;
  logic [2:0]  exp_a, exp_b;
  logic [15:0] rdata, i_d, q_d;
  logic        dv, busy;
  int          n_errors = 0;
  int          n_checks = 0;
  exp_nco_tuner dut (.REF_CLK_I(clk), .RSTN_I(rstn), .REG_ADDR_I(addr),
    .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata),
    .ADC_A_MANT_I(mant_a), .ADC_A_EXP_I(exp_a), .ADC_B_MANT_I(mant_b),
    .ADC_B_EXP_I(exp_b), .SAMPLE_VALID_I(sv), .LEVEL_INDICATOR_I(li),
    .SOFT_SYNC_I(ss), .I_DATA_O(i_d), .Q_DATA_O(q_d), .DATA_VALID_O(dv),
    .HOLDOFF_BUSY_O(busy));
  adc_model #(.BITS(11)) adc (.clk_i(clk), .code_a_i(code_a),
    .code_b_i(code_b), .gain_i(gain), .mant_a_o(mant_a),
    .mant_b_o(mant_b), .exp_a_o(exp_a), .exp_b_o(exp_b));
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want) begin
      n_errors++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
    @(posedge clk);
  endtask
  // Half-scale code 0x200 is 4096; low bits are zero so shifts stay exact
  function automatic logic [15:0] mix_ref(input int s, input int c);
    return 16'(((4096 >>> s) * c) >>> 13);
  endfunction
  task automatic sample(input logic [10:0] ca, input logic [2:0] g);
    int k;
    code_a <= ca;
    code_b <= ca;
    gain <= g;
    @(posedge clk);
    sv <= 1'b1;
    @(posedge clk);
    sv <= 1'b0;
    for (k = 0; k < 4 && dv !== 1'b1; k++)
      @(posedge clk) #1;
    chk(dv, 1'b1);
    @(posedge clk);
  endtask
  task automatic t_regs;
    logic [7:0]  ra [6] = '{8'h84, 8'h85, 8'h86, 8'h87, 8'h88, 8'h92};
    logic [15:0] rm [6] = '{16'hffff, 16'hffff, 16'hffff, 16'hffff,
                            16'h000f, 16'h03ff};
    for (int k = 0; k < 6; k++) begin
      rd_chk(ra[k], 16'h0000);
      wr_reg(ra[k], 16'hffff);
      rd_chk(ra[k], rm[k]);
      wr_reg(ra[k], 16'h0000);
    end
    wr_reg(8'h89, 16'hffff);
    rd_chk(8'h89, 16'h0000);
    wr_reg(8'h00, 16'hffff);
    rd_chk(8'h00, 16'h0000);
  endtask
  task automatic t_scale(input logic inv, input logic [2:0] ofs,
                         input logic [4:0] sc, input logic lv,
                         input logic [2:0] e, input int sh);
    li <= lv;
    wr_reg(8'h91, {12'h000, ofs, inv});
    wr_reg(8'h92, lv ? {6'h00, 5'h01, sc} : {6'h00, sc, 5'h01});
    sample(11'h200, e);
    chk(i_d, mix_ref(sh, 32728));
    chk(q_d, mix_ref(sh, 1608));
  endtask
  task automatic t_bypass;
    wr_reg(8'h88, 16'h0001);
    sample(11'h5a5, 3'h0);
    chk(i_d, {11'h5a5, 5'h00});
    chk(q_d, {11'h5a5, 5'h00});
    wr_reg(8'h88, 16'h0000);
  endtask
  task automatic t_hop;
    int n;
    n = 0;
    wr_reg(8'h85, 16'h5678);
    wr_reg(8'h86, 16'h1234);
    rd_chk(8'h8b, 16'h0000);
    wr_reg(8'h84, 16'h0005);
    addr <= 8'h83;
    wdata <= 16'h0001;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    for (int k = 0; k < 20; k++) begin
      #1 if (busy === 1'b1) n++;
      @(posedge clk);
    end
    chk(n, 6);
    rd_chk(8'h8b, 16'h5678);
    rd_chk(8'h8c, 16'h1234);
    wr_reg(8'h85, 16'h0001);
    wr_reg(8'h84, 16'h0064);
    wr_reg(8'h83, 16'h0001);
    ss <= 1'b1;
    @(posedge clk);
    ss <= 1'b0;
    #1 chk(busy, 1'b0);
    @(posedge clk);
    rd_chk(8'h8b, 16'h0001);
  endtask
  task automatic hop(input logic [15:0] hi, input logic [15:0] ctl);
    wr_reg(8'h85, 16'h0000);
    wr_reg(8'h86, hi);
    wr_reg(8'h88, ctl);
    wr_reg(8'h83, 16'h0002);
  endtask
  task automatic t_phase;
    wr_reg(8'h91, 16'h0000);
    wr_reg(8'h92, 16'h0000);
    hop(16'h4000, 16'h0000);
    sample(11'h200, 3'h0);
    hop(16'h0000, 16'h0008);
    sample(11'h200, 3'h0);
    chk(i_d, mix_ref(0, 32728));
    hop(16'h4000, 16'h0000);
    sample(11'h200, 3'h0);
    hop(16'h0000, 16'h0000);
    sample(11'h200, 3'h0);
    chk(($signed(i_d) < 2000) && ($signed(i_d) > -2000), 1'b1);
    wr_reg(8'h87, 16'hc000);
    sample(11'h200, 3'h0);
    chk(i_d, mix_ref(0, 32728));
    wr_reg(8'h88, 16'h0006);
    sample(11'h200, 3'h0);
    chk(i_d > 16359 && i_d < 16369, 1'b1);
  endtask
  initial begin
    forever #2 clk = ~clk;
  end
  // Whole run is a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_regs();
    t_scale(1'b0, 3'h0, 5'h00, 1'b0, 3'h5, 5);
    t_scale(1'b1, 3'h0, 5'h00, 1'b0, 3'h5, 2);
    t_scale(1'b1, 3'h0, 5'h00, 1'b0, 3'h0, 7);
    t_scale(1'b1, 3'h0, 5'h00, 1'b1, 3'h3, 4);
    t_scale(1'b1, 3'h6, 5'h00, 1'b0, 3'h5, 0);
    t_scale(1'b1, 3'h6, 5'h00, 1'b1, 3'h0, 5);
    t_scale(1'b1, 3'h5, 5'h00, 1'b1, 3'h4, 0);
    t_scale(1'b1, 3'h0, 5'h0b, 1'b1, 3'h6, 4);
    t_scale(1'b1, 3'h3, 5'h06, 1'b0, 3'h0, 0);
    t_bypass();
    t_hop();
    t_phase();
    tally_and_finish();
  end
endmodule
`default_nettype wire
